//--- shared/tcs_pkg.sv
// Overview of operation
// - Control bit 2 picks capture or compare
// - Compare match with counter raises match request
// - Edge code 00 fall, 01 rise, 11 both
// - Second register not loaded by reset
// - Zero second register matches after counter overflow
// - 16-bit counter advances per pulse, reset clears
// - Counter read captures through second register in capture mode with a non-pin count source
// - Clock select resets zero, byte writable
// - Three-bit field selects count source
// - Four-bit field selects clock output rate
// - Clock output driven only while enabled
// - Pin edge filtered by sampling clock choice
// - Mode bit sets main clock full or half
// - Mode field zero stops and clears counter
`default_nettype none
package tcs_pkg;
    localparam logic [15:0] TCS_ADDR_CLKSEL = 16'hff40;
    localparam logic [15:0] TCS_ADDR_MODE   = 16'hff44;
    localparam logic [15:0] TCS_ADDR_OSC    = 16'hff48;
    localparam logic [15:0] TCS_ADDR_CAPCTL = 16'hff4c;
    localparam logic [15:0] TCS_ADDR_EDGE   = 16'hff50;
    localparam logic [15:0] TCS_ADDR_SAMPLE = 16'hff54;
    localparam logic [15:0] TCS_ADDR_CCSEC  = 16'hff58;
    localparam logic [15:0] TCS_ADDR_COUNT  = 16'hff5c;
    localparam logic [15:0] TCS_ADDR_STATUS = 16'hff60;
    localparam logic [15:0] TCS_ADDR_MASK   = 16'hff64;
    localparam logic [15:0] TCS_ADDR_CCFST  = 16'hff68;
    localparam logic [7:0]  TCS_CLKSEL_RST  = 8'h00;
    localparam logic [7:0]  TCS_CAPCTL_RST  = 8'h04;
    localparam int          TCS_CAPSEL_BIT  = 2;
    localparam int          TCS_CLKOE_BIT   = 7;
    localparam logic [2:0]  TCS_SRC_PIN     = 3'h0;
    localparam logic [2:0]  TCS_SRC_2FXX    = 3'h1;
    localparam logic [2:0]  TCS_SRC_FXX     = 3'h2;
    localparam logic [2:0]  TCS_SRC_FXX2    = 3'h3;
    localparam logic [2:0]  TCS_SRC_FXX4    = 3'h4;
    localparam logic [2:0]  TCS_SRC_WATCH   = 3'h7;
    localparam logic [3:0]  TCS_CO_SUB      = 4'h0;
    localparam logic [3:0]  TCS_CO_FIRST    = 4'h5;
    localparam logic [3:0]  TCS_CO_LAST     = 4'hc;
    localparam logic [1:0]  TCS_EDGE_FALL   = 2'h0;
    localparam logic [1:0]  TCS_EDGE_RISE   = 2'h1;
    localparam logic [1:0]  TCS_EDGE_BOTH   = 2'h3;
    localparam logic [2:0]  TCS_MODE_STOP   = 3'h0;
    localparam logic [2:0]  TCS_MODE_EDGCLR = 3'h4;
    localparam logic [2:0]  TCS_MODE_MATCLR = 3'h6;
    localparam int          TCS_ST_MATCH    = 0;
    localparam int          TCS_ST_CAPT     = 1;
    localparam int          TCS_ST_OVF      = 2;
    localparam int          TCS_ST_W        = 3;
    localparam int          TCS_PRE_W       = 9;
    localparam int          TCS_SAMPLE_BASE = 5;
    localparam logic [15:0] TCS_COUNT_MAX   = 16'hffff;
    localparam logic [1:0]  TCS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  TCS_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- logic/tcs_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_timer
    import tcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        edgeInput,
    input  wire logic        watchTimerOutput,
    input  wire logic        subsystemClock,
    output logic             programmableClockOut,
    output logic             clkoutEnable,
    output logic             secondMatchIrq,
    output logic             irq
);
    logic [7:0]  clkSel_r;
    logic [2:0]  mode_r;
    logic        oscMode_r;
    logic [7:0]  capCtl_r;
    logic [1:0]  edgeCode_r;
    logic [1:0]  sampleSel_r;
    logic [15:0] ccSecond_r;
    logic [15:0] ccFirst_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [TCS_ST_W-1:0] status_r;
    logic [TCS_ST_W-1:0] mask_r;
    logic [TCS_PRE_W-1:0] pre_r;
    logic [15:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        awHeld_r;
    logic        wHeld_r;
    logic        doWrite;
    logic        doRead;
    logic        rdHit;
    logic [31:0] rdVal;
    logic        pinSync1_r;
    logic        pinSync2_r;
    logic        pinSmp_r;
    logic        pinLvl_r;
    logic        pinLvlPrev_r;
    logic        watchSync1_r;
    logic        watchSync2_r;
    logic        watchPrev_r;
    logic        validEdge;
    logic        watchEdge;
    logic        sampleTick;
    logic        countTick;
    logic        running;
    logic        captureMode;
    logic        clearNow;
    logic        matchEvt;
    logic        ovfEvt;
    logic        captEvt;
    logic        readCapture;
    logic        clkOutVal;
    logic [3:0]  coDiv;

    // Tick once every 2^k clocks of the prescaler
    function automatic logic divTick(input logic [TCS_PRE_W-1:0] p,
                                     input logic [3:0]           k);
        logic t;
        t = 1'b1;
        for (int i = 0; i < TCS_PRE_W; i++)
        begin
            if (i < int'(k))
                t = t & p[i];
        end
        return t;
    endfunction

    // AXI4-Lite slave, one write and one read at a time
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign doRead  = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 16'h0000;
            wData_r  <= 32'h00000000;
            wStrb_r  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= TCS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_r > TCS_ADDR_CCFST ||
                                 awAddr_r < TCS_ADDR_CLKSEL ||
                                 awAddr_r[1:0] != 2'h0)
                                ? TCS_RESP_SLVERR : TCS_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        rdHit = 1'b1;
        rdVal = 32'h00000000;
        case (s_axi_araddr)
            TCS_ADDR_CLKSEL: rdVal[7:0] = clkSel_r;
            TCS_ADDR_MODE:   rdVal[2:0] = mode_r;
            TCS_ADDR_OSC:    rdVal[0]   = oscMode_r;
            TCS_ADDR_CAPCTL: rdVal[7:0] = capCtl_r;
            TCS_ADDR_EDGE:   rdVal[1:0] = edgeCode_r;
            TCS_ADDR_SAMPLE: rdVal[1:0] = sampleSel_r;
            TCS_ADDR_CCSEC:  rdVal[15:0] = ccSecond_r;
            TCS_ADDR_COUNT:  rdVal[15:0] = count_r;
            TCS_ADDR_STATUS: rdVal[TCS_ST_W-1:0] = status_r;
            TCS_ADDR_MASK:   rdVal[TCS_ST_W-1:0] = mask_r;
            TCS_ADDR_CCFST:  rdVal[15:0] = ccFirst_r;
            default:         rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= TCS_RESP_OKAY;
        end
        else if (doRead)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdVal;
            s_axi_rresp  <= rdHit ? TCS_RESP_OKAY : TCS_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Control registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clkSel_r    <= TCS_CLKSEL_RST;
            mode_r      <= TCS_MODE_STOP;
            oscMode_r   <= 1'b0;
            capCtl_r    <= TCS_CAPCTL_RST;
            edgeCode_r  <= TCS_EDGE_FALL;
            sampleSel_r <= 2'h0;
            mask_r      <= '0;
            ccFirst_r   <= 16'h0000;
        end
        else if (doWrite && wStrb_r[0])
        begin
            case (awAddr_r)
                TCS_ADDR_CLKSEL: clkSel_r <= wData_r[7:0];
                TCS_ADDR_MODE:   mode_r <= wData_r[2:0];
                TCS_ADDR_OSC:    oscMode_r <= wData_r[0];
                TCS_ADDR_CAPCTL: capCtl_r <= wData_r[7:0];
                TCS_ADDR_EDGE:   edgeCode_r <= wData_r[1:0];
                TCS_ADDR_SAMPLE: sampleSel_r <= wData_r[1:0];
                TCS_ADDR_MASK:   mask_r <= wData_r[TCS_ST_W-1:0];
                TCS_ADDR_CCFST:
                begin
                    if (wStrb_r[1])
                        ccFirst_r <= wData_r[15:0];
                end
                default: ;
            endcase
        end
    end

    // Free-running prescaler; fxx is fx or fx/2
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end

    // Synchronise pin and watch timer, filter pin by sampling clock
    assign sampleTick = divTick(pre_r, 4'(TCS_SAMPLE_BASE) + 4'(sampleSel_r));
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinSync1_r   <= 1'b0;
            pinSync2_r   <= 1'b0;
            pinSmp_r     <= 1'b0;
            pinLvl_r     <= 1'b0;
            pinLvlPrev_r <= 1'b0;
            watchSync1_r <= 1'b0;
            watchSync2_r <= 1'b0;
            watchPrev_r  <= 1'b0;
        end
        else
        begin
            pinSync1_r   <= edgeInput;
            pinSync2_r   <= pinSync1_r;
            watchSync1_r <= watchTimerOutput;
            watchSync2_r <= watchSync1_r;
            watchPrev_r  <= watchSync2_r;
            pinLvlPrev_r <= pinLvl_r;
            if (sampleTick)
            begin
                pinSmp_r <= pinSync2_r;
                if (pinSmp_r == pinSync2_r)
                    pinLvl_r <= pinSync2_r;
            end
        end
    end

    always_comb
    begin
        case (edgeCode_r)
            TCS_EDGE_FALL: validEdge = pinLvlPrev_r && !pinLvl_r;
            TCS_EDGE_RISE: validEdge = !pinLvlPrev_r && pinLvl_r;
            TCS_EDGE_BOTH: validEdge = pinLvlPrev_r != pinLvl_r;
            default:       validEdge = 1'b0;
        endcase
    end
    assign watchEdge = watchSync2_r && !watchPrev_r;

    // Count source select; mode bit clear halves fxx
    always_comb
    begin
        case (clkSel_r[6:4])
            TCS_SRC_PIN:   countTick = validEdge;
            TCS_SRC_2FXX:  countTick = oscMode_r ? divTick(pre_r, 4'h0) : 1'b1;
            TCS_SRC_FXX:   countTick = divTick(pre_r, 4'h0 + 4'(!oscMode_r));
            TCS_SRC_FXX2:  countTick = divTick(pre_r, 4'h1 + 4'(!oscMode_r));
            TCS_SRC_FXX4:  countTick = divTick(pre_r, 4'h2 + 4'(!oscMode_r));
            TCS_SRC_WATCH: countTick = watchEdge;
            default:       countTick = 1'b0;
        endcase
    end

    // Counter
    assign running = mode_r != TCS_MODE_STOP;
    assign captureMode = capCtl_r[TCS_CAPSEL_BIT];
    assign clearNow = (mode_r[2:1] == TCS_MODE_EDGCLR[2:1] && validEdge) ||
                      (mode_r[2:1] == TCS_MODE_MATCLR[2:1] &&
                       countTick && count_r == ccFirst_r);
    always_comb
    begin
        count_nxt = count_r;
        if (!running)
            count_nxt = 16'h0000;
        else if (clearNow)
            count_nxt = 16'h0000;
        else if (countTick)
            count_nxt = count_r + 1'b1;
    end
    assign ovfEvt = running && countTick && !clearNow &&
                    count_r == TCS_COUNT_MAX;
    // Match only when the count moves, so zero hits right after wrap
    assign matchEvt = running && !captureMode && count_nxt != count_r &&
                      count_nxt == ccSecond_r;
    assign captEvt = running && captureMode && validEdge;
    assign readCapture = doRead && s_axi_araddr == TCS_ADDR_COUNT &&
                         captureMode && clkSel_r[6:4] != TCS_SRC_PIN;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count_r <= 16'h0000;
        else
            count_r <= count_nxt;
    end

    // Second register has no reset value
    always_ff @(posedge clk)
    begin
        if (captEvt)
            ccSecond_r <= count_r;
        else if (readCapture)
            ccSecond_r <= count_r;
        else if (doWrite && awAddr_r == TCS_ADDR_CCSEC && &wStrb_r[1:0])
            ccSecond_r <= wData_r[15:0];
    end

    // Sticky status, cleared by read, set wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_r       <= '0;
            secondMatchIrq <= 1'b0;
        end
        else
        begin
            secondMatchIrq <= matchEvt;
            if (doRead && s_axi_araddr == TCS_ADDR_STATUS)
                status_r <= '0;
            if (matchEvt)
                status_r[TCS_ST_MATCH] <= 1'b1;
            if (captEvt)
                status_r[TCS_ST_CAPT] <= 1'b1;
            if (ovfEvt)
                status_r[TCS_ST_OVF] <= 1'b1;
        end
    end
    assign irq = |(status_r & mask_r);

    // Clock output, fxx/2^n from prescaler taps
    assign coDiv = clkSel_r[3:0] - TCS_CO_FIRST + 4'(!oscMode_r);
    always_comb
    begin
        clkOutVal = 1'b0;
        if (clkSel_r[3:0] == TCS_CO_SUB)
            clkOutVal = subsystemClock;
        else if (clkSel_r[3:0] >= TCS_CO_FIRST &&
                 clkSel_r[3:0] <= TCS_CO_LAST)
            clkOutVal = (coDiv == 4'h0) ? pre_r[0] : pre_r[coDiv - 1'b1];
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            programmableClockOut <= 1'b0;
        else
            programmableClockOut <= clkSel_r[TCS_CLKOE_BIT] && clkOutVal;
    end
    assign clkoutEnable = clkSel_r[TCS_CLKOE_BIT];

    a_stop_clears: assert property (
        @(posedge clk) disable iff (!reset_n)
        !running |=> count_r == 16'h0000)
        else $error("counter not cleared while stopped");
    a_count_step: assert property (
        @(posedge clk) disable iff (!reset_n)
        running && countTick && !clearNow |=>
        count_r == $past(count_r) + 16'h0001)
        else $error("counter did not advance");
    a_match_pulse: assert property (
        @(posedge clk) disable iff (!reset_n)
        matchEvt |=> secondMatchIrq && status_r[TCS_ST_MATCH])
        else $error("match not reported");
    a_zero_wrap: assert property (
        @(posedge clk) disable iff (!reset_n)
        ovfEvt && !captureMode && ccSecond_r == 16'h0000 |=>
        secondMatchIrq)
        else $error("zero compare missed after wrap");
    a_capture_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        captEvt |=> ccSecond_r == $past(count_r))
        else $error("capture value wrong");
    a_read_capture: assert property (
        @(posedge clk) disable iff (!reset_n)
        readCapture |=> ccSecond_r == $past(count_r) && s_axi_rvalid)
        else $error("counter read did not capture");
    a_clkout_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        !clkSel_r[TCS_CLKOE_BIT] |=> !programmableClockOut)
        else $error("clock output active while disabled");
    a_pin_sync: assert property (
        @(posedge clk) disable iff (!reset_n)
        validEdge |-> $past(pinSync2_r, 2) == pinLvl_r)
        else $error("pin edge not filtered");
    a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(status_r[TCS_ST_OVF]) && mask_r[TCS_ST_OVF] |-> irq)
        else $error("irq not raised");
endmodule
`default_nettype wire

//--- verif/tcs_edge_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_edge_model (
    input  wire logic       clk,
    input  wire logic       pinReq,
    input  wire logic       watchReq,
    input  wire logic [4:0] lag,
    output logic            edgeInput,
    output logic            watchTimerOutput,
    output logic            subsystemClock
);
    // Slow free-running stand-in for the subsystem oscillator
    initial
    begin
        edgeInput = 1'b0;
        watchTimerOutput = 1'b0;
        subsystemClock = 1'b0;
        forever
        begin
            repeat (32) @(posedge clk);
            subsystemClock <= !subsystemClock;
        end
    end
    // Pin flips after a lag, then stands until the next request
    always @(posedge clk)
        if (pinReq)
        begin
            repeat (lag) @(posedge clk);
            edgeInput <= !edgeInput;
        end
    always @(posedge clk)
        if (watchReq)
        begin
            repeat (lag) @(posedge clk);
            watchTimerOutput <= 1'b1;
            repeat (4) @(posedge clk);
            watchTimerOutput <= 1'b0;
        end
endmodule
`default_nettype wire

//--- verif/tcs_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_timer_tb
    import tcs_pkg::*;
    ;
    typedef struct {logic [31:0] e; logic [31:0] m; logic [1:0] r;} tcs_note_t;
    logic        clk;
    logic        reset_n;
    logic [15:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        edgeInput;
    logic        watchTimerOutput;
    logic        subsystemClock;
    logic        pclkOut;
    logic        clkoutEnable;
    logic        secondMatchIrq;
    logic        irq;
    logic        pinReq;
    logic        watchReq;
    logic [4:0]  lag;
    logic [31:0] lastRd;
    int          fails = 0;
    int          nCompared = 0;
    tcs_note_t   monNote;
    tcs_note_t   rq[$];
    logic [1:0]  bq[$];
    logic [2:0]  srcTab [6] = '{TCS_SRC_2FXX, TCS_SRC_FXX, TCS_SRC_FXX,
                                TCS_SRC_FXX2, TCS_SRC_FXX4, TCS_SRC_FXX4};
    logic        oscTab [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int          divTab [6] = '{1, 1, 2, 2, 4, 8};
    logic [1:0]  edgeTab [3] = '{TCS_EDGE_FALL, TCS_EDGE_RISE, TCS_EDGE_BOTH};

    tcs_timer i_tcs_timer (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .edgeInput(edgeInput),
        .watchTimerOutput(watchTimerOutput),
        .subsystemClock(subsystemClock), .programmableClockOut(pclkOut),
        .clkoutEnable(clkoutEnable), .secondMatchIrq(secondMatchIrq),
        .irq(irq)
    );
    tcs_edge_model i_tcs_edge_model (
        .clk(clk), .pinReq(pinReq), .watchReq(watchReq), .lag(lag),
        .edgeInput(edgeInput), .watchTimerOutput(watchTimerOutput),
        .subsystemClock(subsystemClock)
    );

    initial
    begin
        clk = 1'b0;
        forever
            #4 clk = !clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic span(input logic [31:0] v, input int lo, input int hi);
        check({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'h1,
                      input logic [1:0] er = TCS_RESP_OKAY);
        @(posedge clk);
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e,
                      input logic [31:0] m,
                      input logic [1:0] er = TCS_RESP_OKAY);
        tcs_note_t nt;
        nt = '{e, m, er};
        @(posedge clk);
        rq.push_back(nt);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic measure(output logic [31:0] t);
        logic prev;
        t = 32'h0;
        prev = pclkOut;
        repeat (512)
        begin
            @(posedge clk);
            t = t + 32'(pclkOut != prev);
            prev = pclkOut;
        end
    endtask

    task automatic waitMatch(output logic [31:0] t);
        t = 32'h0;
        do
        begin
            @(posedge clk);
            t = t + 32'h1;
        end
        while (secondMatchIrq !== 1'b1 && t < 70000);
    endtask

    task automatic poke(input logic w, input int gap);
        @(posedge clk);
        lag <= 5'($urandom_range(20));
        pinReq <= !w;
        watchReq <= w;
        @(posedge clk);
        pinReq <= 1'b0;
        watchReq <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask

    // Takes the oldest note whenever a response completes
    always @(posedge clk)
    begin
        if (rvalid && rready && rq.size() > 0)
        begin
            monNote = rq.pop_front();
            lastRd <= rdata;
            check(rdata & monNote.m, monNote.e & monNote.m);
            check({30'h0, rresp}, {30'h0, monNote.r});
        end
        if (bvalid && bready && bq.size() > 0)
            check({30'h0, bresp}, {30'h0, bq.pop_front()});
    end

    initial
    begin
        repeat (98000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial
    begin
        logic [31:0] t;
        logic [31:0] c0;
        logic [3:0]  c;
        int          per;
        int          n;
        reset_n = 1'b0;
        awaddr = 16'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 16'h0;
        arvalid = 1'b0;
        rready = 1'b0;
        pinReq = 1'b0;
        watchReq = 1'b0;
        lag = 5'($urandom(15160));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(TCS_ADDR_CLKSEL, 32'h0, 32'hff);
        rd(TCS_ADDR_CAPCTL, 32'h4, 32'hff);
        rd(TCS_ADDR_COUNT, 32'h0, 32'hffff);
        rd(16'hff70, 32'h0, 32'hffffffff, TCS_RESP_SLVERR);
        wr(16'hff70, 32'h0, 4'hf, TCS_RESP_SLVERR);
        $display("Reset and map test done");
        for (int o = 1; o >= 0; o--)
        begin
            wr(TCS_ADDR_OSC, 32'(o));
            for (int k = 4; k <= 12; k++)
            begin
                c = (k == 4) ? TCS_CO_SUB : 4'(k);
                wr(TCS_ADDR_CLKSEL, {28'h0, c});
                repeat (4) @(posedge clk);
                measure(t);
                check(t | {31'h0, pclkOut}, 32'h0);
                check({31'h0, clkoutEnable}, 32'h0);
                wr(TCS_ADDR_CLKSEL, 32'h80 | {28'h0, c});
                rd(TCS_ADDR_CLKSEL, 32'h80 | {28'h0, c}, 32'hff);
                check({31'h0, clkoutEnable}, 32'h1);
                per = (k == 4) ? 64 : 1 << (k - 4 - o);
                per = (per < 2) ? 2 : per;
                measure(t);
                span(t, 1024 / per - 1, 1024 / per + 1);
            end
        end
        $display("Clock output test done");
        foreach (srcTab[i])
        begin
            wr(TCS_ADDR_MODE, 32'h0);
            wr(TCS_ADDR_OSC, {31'h0, oscTab[i]});
            wr(TCS_ADDR_CLKSEL, {25'h0, srcTab[i], 4'h0});
            wr(TCS_ADDR_MODE, 32'h2);
            rd(TCS_ADDR_COUNT, 32'h0, 32'h0);
            @(posedge clk);
            c0 = lastRd;
            repeat (255) @(posedge clk);
            rd(TCS_ADDR_COUNT, 32'h0, 32'h0);
            @(posedge clk);
            span(lastRd - c0, 259 / divTab[i] - 1, 259 / divTab[i] + 1);
        end
        rd(TCS_ADDR_COUNT, 32'h0, 32'h0);
        @(posedge clk);
        rd(TCS_ADDR_CCSEC, lastRd, 32'hffff);
        wr(TCS_ADDR_MODE, 32'h0);
        rd(TCS_ADDR_COUNT, 32'h0, 32'hffff);
        $display("Count source test done");
        wr(TCS_ADDR_CAPCTL, 32'h0);
        wr(TCS_ADDR_OSC, 32'h1);
        wr(TCS_ADDR_CLKSEL, {25'h0, TCS_SRC_FXX, 4'h0});
        n = $urandom_range(200, 40);
        wr(TCS_ADDR_CCSEC, 32'(n), 4'h3);
        rd(TCS_ADDR_STATUS, 32'h0, 32'h0);
        wr(TCS_ADDR_MODE, 32'h2);
        waitMatch(t);
        span(t, n - 6, n + 4);
        @(posedge clk);
        check({31'h0, secondMatchIrq}, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(TCS_ADDR_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd(TCS_ADDR_STATUS, 32'h1, 32'h1);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(TCS_ADDR_MODE, 32'h0);
        wr(TCS_ADDR_CCSEC, 32'h0, 4'h3);
        wr(TCS_ADDR_MODE, 32'h2);
        waitMatch(t);
        span(t, 65530, 65542);
        rd(TCS_ADDR_STATUS, 32'h5, 32'h5);
        wr(TCS_ADDR_MODE, 32'h0);
        wr(TCS_ADDR_CCFST, 32'(n), 4'h3);
        wr(TCS_ADDR_CCSEC, 32'(n), 4'h3);
        rd(TCS_ADDR_STATUS, 32'h0, 32'h0);
        wr(TCS_ADDR_MODE, {29'h0, TCS_MODE_MATCLR});
        repeat (3 * n) @(posedge clk);
        rd(TCS_ADDR_COUNT, 32'h0, 32'h0);
        @(posedge clk);
        span(lastRd, 0, n);
        rd(TCS_ADDR_STATUS, 32'h1, 32'h5);
        $display("Compare and interrupt test done");
        wr(TCS_ADDR_MODE, 32'h0);
        wr(TCS_ADDR_CAPCTL, 32'h4);
        wr(TCS_ADDR_CLKSEL, {25'h0, TCS_SRC_PIN, 4'h0});
        wr(TCS_ADDR_SAMPLE, 32'h0);
        foreach (edgeTab[i])
        begin
            wr(TCS_ADDR_MODE, 32'h0);
            wr(TCS_ADDR_EDGE, {30'h0, edgeTab[i]});
            wr(TCS_ADDR_MODE, 32'h2);
            rd(TCS_ADDR_STATUS, 32'h0, 32'h0);
            repeat (6) poke(1'b0, 200);
            rd(TCS_ADDR_COUNT, (i == 2) ? 32'h6 : 32'h3, 32'hffff);
            rd(TCS_ADDR_CCSEC, (i == 2) ? 32'h5 : 32'h2, 32'hffff);
            rd(TCS_ADDR_STATUS, 32'h2, 32'h2);
        end
        wr(TCS_ADDR_MODE, 32'h0);
        wr(TCS_ADDR_CLKSEL, {25'h0, TCS_SRC_WATCH, 4'h0});
        wr(TCS_ADDR_MODE, {29'h0, TCS_MODE_EDGCLR});
        repeat (5) poke(1'b1, 40);
        rd(TCS_ADDR_COUNT, 32'h5, 32'hffff);
        poke(1'b0, 200);
        rd(TCS_ADDR_COUNT, 32'h0, 32'hffff);
        $display("Edge and watch source test done");
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
